// file: sadc_comp_model.sv
`timescale 1ns/1ps
// input mux and comparator stand-in: each channel holds a fixed level
module sadc_comp_model (
	input  wire sadc_pkg::sadc_ana_t ana,
	output logic                     comp_in
);
	logic [11:0] level;

	// level per channel code, routed or not, judged against the current trial code
	always_comb begin
		level = 12'(ana.channel * 12'h123) ^ 12'h5A6;
		comp_in = (level >= ana.trial);
	end
endmodule

// file: sadc_ctrl.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module sadc_ctrl (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire sadc_pkg::sadc_bus_t bus,
	output logic [7:0]             rdata,
	input  wire logic              comp_in,
	output sadc_pkg::sadc_ana_t    ana,
	output logic                   busy,
	output logic                   irq
);
	typedef struct packed {
		sadc_pkg::sadc_state_t state;
		logic [4:0]            cnt;
		logic [7:0]            option;
		logic                  start;
		logic                  done;
		logic [3:0]            chan;
		logic [3:0]            chan_cap;
		logic [11:0]           sar;
		logic [11:0]           result;
		logic [1:0]            stat;
		logic [1:0]            mask;
		logic [7:0]            rdata;
		logic [5:0]            ticks;
	} sadc_ctrl_st_t;

	localparam sadc_ctrl_st_t RST = '{
		state:    sadc_pkg::SADC_IDLE,
		cnt:      5'h00,
		option:   sadc_pkg::OPTION_RST,
		start:    1'b0,
		done:     1'b0,
		chan:     sadc_pkg::CHAN_RST,
		chan_cap: sadc_pkg::CHAN_RST,
		sar:      12'h000,
		result:   12'h000,
		stat:     2'h0,
		mask:     sadc_pkg::MASK_RST,
		rdata:    8'h00,
		ticks:    6'h00
	};

	sadc_ctrl_st_t r;
	sadc_ctrl_st_t n;
	logic          tick;
	logic          comp;
	logic          start_go;
	logic          abort;
	logic [3:0]    idx;
	logic [11:0]   sar_t;
	logic [1:0]    div_sel;

	assign div_sel = r.option[sadc_pkg::DIV_LSB +: 2];

	// converter clock strobe, restarted so every run sees whole periods
	sadc_tick u_tick (
		.clk     (clk),
		.reset   (reset),
		.sel     (div_sel),
		.restart (start_go),
		.tick    (tick)
	);

	// comparator answer arrives from the analog side, off-domain
	sadc_sync u_sync (
		.clk   (clk),
		.reset (reset),
		.din   (comp_in),
		.dout  (comp)
	);

	// register writes, reads and the conversion sequencer
	always_comb begin
		n = r;
		n.rdata = 8'h00;
		start_go = 1'b0;
		abort = 1'b0;
		idx = 4'(4'hB - r.cnt[4:1]);
		sar_t = r.sar;

		// software side first, so hardware sets below win a tie, except that an abort write drops the tick
		if (bus.we) begin
			if (bus.addr == sadc_pkg::OPTION_ADDR) begin
				n.option = bus.wdata;
			end else if (bus.addr == sadc_pkg::FLAG_ADDR) begin
				if (!bus.wdata[sadc_pkg::DONE_BIT]) begin
					n.done = 1'b0;
				end
			end else if (bus.addr == sadc_pkg::CHAN_ADDR) begin
				n.chan = bus.wdata[sadc_pkg::CHAN_LSB +: 4];
			end else if (bus.addr == sadc_pkg::AUX_ADDR) begin
				if (bus.wdata[sadc_pkg::START_BIT]) begin
					if (r.state == sadc_pkg::SADC_IDLE) begin
						start_go = 1'b1;
					end else begin
						// a second start cannot restart a busy run
						n.stat[sadc_pkg::IRQ_OVR] = 1'b1;
					end
				end else begin
					n.start = 1'b0;
					abort = r.state != sadc_pkg::SADC_IDLE;
				end
			end else if (bus.addr == sadc_pkg::IRQ_STAT_ADDR) begin
				n.stat = r.stat & ~bus.wdata[1:0];
			end else if (bus.addr == sadc_pkg::IRQ_MASK_ADDR) begin
				n.mask = bus.wdata[1:0];
			end
		end

		// read data stands only in the cycle after the strobe
		if (bus.re) begin
			if (bus.addr == sadc_pkg::OPTION_ADDR) begin
				n.rdata = r.option;
			end else if (bus.addr == sadc_pkg::FLAG_ADDR) begin
				n.rdata = 8'({r.done, 4'h0});
			end else if (bus.addr == sadc_pkg::RES_LO_ADDR) begin
				n.rdata = {r.result[3:0], 4'h0};
			end else if (bus.addr == sadc_pkg::RES_HI_ADDR) begin
				n.rdata = r.result[11:4];
			end else if (bus.addr == sadc_pkg::CHAN_ADDR) begin
				n.rdata = {r.chan, 4'h0};
			end else if (bus.addr == sadc_pkg::AUX_ADDR) begin
				n.rdata = 8'({r.start, 4'h0});
			end else if (bus.addr == sadc_pkg::IRQ_STAT_ADDR) begin
				n.rdata = {6'h00, r.stat};
			end else if (bus.addr == sadc_pkg::IRQ_MASK_ADDR) begin
				n.rdata = {6'h00, r.mask};
			end
		end

		if (start_go) begin
			n.start = 1'b1;
			n.done = 1'b0;
			n.chan_cap = r.chan;
			n.state = sadc_pkg::SADC_SAMPLE;
			n.cnt = 5'h00;
			n.sar = 12'h000;
			n.ticks = 6'h00;
		end else if (abort) begin
			// a cleared start bit drops the run, result kept
			n.state = sadc_pkg::SADC_IDLE;
			n.cnt = 5'h00;
		end else if (tick) begin
			if (r.state != sadc_pkg::SADC_IDLE) begin
				n.ticks = r.ticks + 6'h01;
			end
			case (r.state)
				sadc_pkg::SADC_SAMPLE: begin
					// hold phase fills what the bit phases leave of 50
					if (r.cnt == sadc_pkg::SAMPLE_LAST) begin
						n.state = sadc_pkg::SADC_CONVERT;
						n.cnt = 5'h00;
					end else begin
						n.cnt = r.cnt + 5'h01;
					end
				end
				sadc_pkg::SADC_CONVERT: begin
					// first clock drives the trial, second judges it
					sar_t[idx] = r.cnt[0] ? comp : 1'b1;
					n.sar = sar_t;
					n.cnt = r.cnt + 5'h01;
					if (r.cnt == sadc_pkg::CONV_LAST) begin
						n.state = sadc_pkg::SADC_IDLE;
						n.cnt = 5'h00;
						n.result = sar_t;
						n.done = 1'b1;
						n.start = 1'b0;
						n.stat[sadc_pkg::IRQ_DONE] = 1'b1;
					end
				end
				default: begin
					n.cnt = 5'h00;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= RST;
		end else begin
			r <= n;
		end
	end

	// analog side follows the captured channel, not the live field
	assign ana.sample = r.state == sadc_pkg::SADC_SAMPLE;
	assign ana.convert = r.state == sadc_pkg::SADC_CONVERT;
	assign ana.channel = r.chan_cap;
	assign ana.route_en = r.chan_cap != sadc_pkg::CH_RSVD;
	assign ana.trial = r.sar;
	assign busy = r.state != sadc_pkg::SADC_IDLE;
	assign rdata = r.rdata;
	// level request, only through the enable mask
	assign irq = |(r.stat & r.mask);

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence aux_write(logic v);
		bus.we && bus.addr == sadc_pkg::AUX_ADDR
			&& bus.wdata[sadc_pkg::START_BIT] == v;
	endsequence

	sequence read_of(logic [7:0] a);
		bus.re && bus.addr == a;
	endsequence

	AST_START_RUNS: assert property (
		aux_write(1'b1) ##0 (r.state == sadc_pkg::SADC_IDLE)
		|=> r.start && r.state == sadc_pkg::SADC_SAMPLE && !r.done)
		else $error("start write did not begin a conversion");

	AST_SW_CLEAR: assert property (
		aux_write(1'b0) |=> !r.start && r.state == sadc_pkg::SADC_IDLE)
		else $error("zero write did not clear start");

	AST_DONE_IRQ: assert property (
		$rose(r.done) |-> r.stat[sadc_pkg::IRQ_DONE]
		&& irq == (r.mask[sadc_pkg::IRQ_DONE] || (r.stat[1] && r.mask[1])))
		else $error("done event and interrupt disagree");

	AST_FLAG_CLR: assert property (
		bus.we && bus.addr == sadc_pkg::FLAG_ADDR
		&& !bus.wdata[sadc_pkg::DONE_BIT]
		&& r.state != sadc_pkg::SADC_CONVERT |=> !r.done)
		else $error("done flag survived zero write");

	AST_CONV_LEN: assert property (
		$rose(r.done) |-> r.ticks == 6'(sadc_pkg::CONV_TICKS))
		else $error("conversion length not fifty clocks");

	AST_LOAD: assert property (
		$rose(r.done) |-> $past(r.state) == sadc_pkg::SADC_CONVERT
		&& !r.start && $changed(r.ticks) && r.result == r.sar)
		else $error("result loaded without done");

	AST_RES_HI: assert property (
		read_of(sadc_pkg::RES_HI_ADDR) |=> rdata == $past(r.result[11:4]))
		else $error("high result read wrong");

	AST_RES_LO: assert property (
		read_of(sadc_pkg::RES_LO_ADDR)
		|=> rdata == {$past(r.result[3:0]), 4'h0})
		else $error("low result read wrong");

	AST_CHAN_HOLD: assert property (
		busy && $past(busy) |-> $stable(ana.channel))
		else $error("channel moved during conversion");

	// final judging tick, not overtaken by a start or abort write
	sequence last_tick;
		tick && r.state == sadc_pkg::SADC_CONVERT
			&& r.cnt == sadc_pkg::CONV_LAST
			&& !(bus.we && bus.addr == sadc_pkg::AUX_ADDR);
	endsequence

	AST_END_SETS: assert property (
		last_tick |=> r.done && !busy && !r.start
		&& r.stat[sadc_pkg::IRQ_DONE])
		else $error("end of conversion did not raise done");

	AST_LOAD_TRIAL: assert property (
		last_tick |=> r.result[11:1] == $past(r.sar[11:1])
		&& r.result[0] == $past(comp))
		else $error("result not taken from the final trial");

	// hold phase is what the bit phases leave of the fifty
	AST_HOLD_LEN: assert property (
		$fell(ana.sample) && ana.convert
		|-> r.ticks == 6'(sadc_pkg::SAMPLE_LAST) + 6'h01)
		else $error("hold phase length wrong");

	AST_PHASES: assert property (
		busy |-> ana.sample ^ ana.convert)
		else $error("sample and convert phases overlap");

	AST_OVERRUN: assert property (
		aux_write(1'b1) ##0 (busy && !tick)
		|=> r.stat[sadc_pkg::IRQ_OVR] && busy && $stable(ana.channel))
		else $error("start while busy disturbed the run");

	AST_CAPTURE: assert property (
		aux_write(1'b1) ##0 !busy |=> ana.channel == $past(r.chan))
		else $error("channel not captured at start");

	AST_RESERVED: assert property (
		busy && ana.channel == sadc_pkg::CH_RSVD |-> !ana.route_en)
		else $error("reserved channel routed to the converter");

	AST_RO_RESULT: assert property (
		bus.we && !busy && (bus.addr == sadc_pkg::RES_HI_ADDR
		|| bus.addr == sadc_pkg::RES_LO_ADDR) |=> $stable(r.result))
		else $error("result register took a write");

	AST_DIV_SEL: assert property (
		bus.we && bus.addr == sadc_pkg::OPTION_ADDR
		|=> div_sel == $past(bus.wdata[sadc_pkg::DIV_LSB +: 2]))
		else $error("divider select write lost");
endmodule

// file: sadc_ctrl_tb.sv
`timescale 1ns/1ps
module sadc_ctrl_tb;
	logic                clk;
	logic                reset;
	sadc_pkg::sadc_bus_t bus;
	logic [7:0]          rdata;
	logic                comp_in;
	sadc_pkg::sadc_ana_t ana;
	logic                busy;
	logic                irq;
	int                  n_fail = 0;
	int                  tests_run = 0;
	logic [11:0]         e;
	logic [3:0]          chs [5] = '{4'h0, 4'hB, 4'hC, 4'hE, 4'hF};

	sadc_ctrl sadc_ctrl_inst (
		.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
		.comp_in(comp_in), .ana(ana), .busy(busy), .irq(irq));
	sadc_comp_model sadc_comp_model_inst (.ana(ana), .comp_in(comp_in));

	// 125 MHz system clock
	initial clk = 1'b0;
	always #4 clk = ~clk;

	// analog level that the stand-in presents on a channel
	function automatic logic [11:0] level_of(input logic [3:0] ch);
		return 12'(ch * 12'h123) ^ 12'h5A6;
	endfunction

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe, released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk({4'h0, rdata}, {4'h0, exp});
	endtask

	// one full conversion; channel rewritten mid-run must not take hold
	task automatic conv(input logic [1:0] sel, input logic [3:0] ch);
		int n;
		int d;
		logic [11:0] ph;
		logic ok;
		n = 0;
		d = 32 >> sel;
		e = level_of(ch);
		// hold phase first; reserved code must not be routed
		ph = {9'h0, 1'b1, 1'b0, ch != sadc_pkg::CH_RSVD};
		wr(sadc_pkg::OPTION_ADDR, {4'h0, sel, 2'h0});
		wr(sadc_pkg::CHAN_ADDR, {ch, 4'h0});
		wr(sadc_pkg::AUX_ADDR, 8'h10);
		#1 chk({11'h0, busy}, 12'h001);
		chk({9'h0, ana.sample, ana.convert, ana.route_en}, ph);
		wr(sadc_pkg::CHAN_ADDR, {~ch, 4'h0});
		#1 chk({8'h0, ana.channel}, {8'h0, ch});
		while (busy === 1'b1 && n < 3000) begin
			@(posedge clk);
			#1 n++;
			if (n == 27 * d)
				chk({10'h0, ana.sample, ana.convert}, 12'h001);
		end
		// two edges already spent on the mid-run channel write
		ok = (n + 2 >= 50 * d) && (n + 2 <= 50 * d + 3);
		chk({11'h0, ok}, 12'h001);
		chk({10'h0, ana.sample, ana.convert}, 12'h000);
		chk(ana.trial, e);
		rc(sadc_pkg::RES_HI_ADDR, e[11:4]);
		rc(sadc_pkg::RES_LO_ADDR, {e[3:0], 4'h0});
		rc(sadc_pkg::FLAG_ADDR, 8'h10);
		rc(sadc_pkg::AUX_ADDR, 8'h00);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// hang guard, well past the longest expected run
	initial begin
		#(8 * 20000);
		n_fail++;
		close_out;
	end

	initial begin
		reset = 1'b1;
		bus = '0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		rc(sadc_pkg::OPTION_ADDR, 8'h00);
		rc(sadc_pkg::CHAN_ADDR, 8'hF0);
		rc(sadc_pkg::AUX_ADDR, 8'h00);
		rc(sadc_pkg::FLAG_ADDR, 8'h00);
		wr(sadc_pkg::IRQ_MASK_ADDR, 8'h01);
		// every divider code, pins and internal sources
		for (int i = 0; i < 5; i++) begin
			conv(2'(i), chs[i]);
			#1 chk({11'h0, irq}, 12'h001);
			wr(sadc_pkg::IRQ_STAT_ADDR, 8'h01);
			#1 chk({11'h0, irq}, 12'h000);
			wr(sadc_pkg::FLAG_ADDR, 8'hEF);
			rc(sadc_pkg::FLAG_ADDR, 8'h00);
		end
		// masked: event is recorded but the line stays low
		wr(sadc_pkg::IRQ_MASK_ADDR, 8'h00);
		conv(2'h3, 4'h5);
		#1 chk({11'h0, irq}, 12'h000);
		wr(sadc_pkg::AUX_ADDR, 8'h10);
		rc(sadc_pkg::FLAG_ADDR, 8'h00);
		wr(sadc_pkg::AUX_ADDR, 8'h10);
		rc(sadc_pkg::IRQ_STAT_ADDR, 8'h03);
		// software zero stops the run, no done and result kept
		wr(sadc_pkg::AUX_ADDR, 8'h00);
		#1 chk({11'h0, busy}, 12'h000);
		rc(sadc_pkg::AUX_ADDR, 8'h00);
		rc(sadc_pkg::FLAG_ADDR, 8'h00);
		rc(sadc_pkg::RES_HI_ADDR, e[11:4]);
		conv(2'h2, 4'h9);
		wr(sadc_pkg::FLAG_ADDR, 8'h00);
		rc(sadc_pkg::FLAG_ADDR, 8'h00);
		wr(sadc_pkg::RES_HI_ADDR, 8'h00);
		wr(sadc_pkg::RES_LO_ADDR, 8'hFF);
		rc(sadc_pkg::RES_HI_ADDR, e[11:4]);
		rc(sadc_pkg::RES_LO_ADDR, {e[3:0], 4'h0});
		rc(8'h00, 8'h00);
		// reserved code still converts, but is not routed
		conv(2'h3, sadc_pkg::CH_RSVD);
		close_out;
	end
endmodule

// file: sadc_pkg.sv
package sadc_pkg;
	// register offsets on the special-function bus
	localparam logic [7:0] OPTION_ADDR   = 8'h94;
	localparam logic [7:0] FLAG_ADDR     = 8'h95;
	localparam logic [7:0] RES_LO_ADDR   = 8'hAA;
	localparam logic [7:0] RES_HI_ADDR   = 8'hAB;
	localparam logic [7:0] CHAN_ADDR     = 8'hAE;
	localparam logic [7:0] AUX_ADDR      = 8'hF8;
	localparam logic [7:0] IRQ_STAT_ADDR = 8'hB0;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'hB1;

	// field positions
	localparam int DIV_LSB   = 2;
	localparam int START_BIT = 4;
	localparam int DONE_BIT  = 4;
	localparam int CHAN_LSB  = 4;
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_OVR   = 1;

	// values after reset
	localparam logic [7:0] OPTION_RST = 8'h00;
	localparam logic [3:0] CHAN_RST   = 4'hF;
	localparam logic [1:0] MASK_RST   = 2'h0;

	// divider terminal counts, indexed by the select code
	localparam logic [3:0][4:0] DIV_TC = {5'h03, 5'h07, 5'h0F, 5'h1F};

	// conversion timing in converter clocks
	localparam int CONV_TICKS = 50;
	localparam int RES_BITS   = 12;
	localparam int BIT_TICKS  = 2;
	localparam logic [4:0] SAMPLE_LAST =
		5'(CONV_TICKS - RES_BITS * BIT_TICKS - 1);
	localparam logic [4:0] CONV_LAST = 5'(RES_BITS * BIT_TICKS - 1);

	// channel codes
	localparam logic [3:0] CH_BANDGAP = 4'hC;
	localparam logic [3:0] CH_RSVD    = 4'hD;
	localparam logic [3:0] CH_OPAMP   = 4'hE;
	localparam logic [3:0] CH_GND     = 4'hF;

	typedef enum logic [1:0] {
		SADC_IDLE    = 2'b00,
		SADC_SAMPLE  = 2'b01,
		SADC_CONVERT = 2'b11
	} sadc_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} sadc_bus_t;

	typedef struct packed {
		logic        sample;
		logic        convert;
		logic        route_en;
		logic [3:0]  channel;
		logic [11:0] trial;
	} sadc_ana_t;
endpackage

// file: sadc_sync.sv
`timescale 1ns/1ps
module sadc_sync (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic s1;
		logic s2;
	} sadc_sync_st_t;

	sadc_sync_st_t r;
	sadc_sync_st_t n;

	// first stage feeds only the second stage
	always_comb begin
		n.s1 = din;
		n.s2 = r.s1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign dout = r.s2;
endmodule

// file: sadc_tick.sv
`timescale 1ns/1ps
module sadc_tick (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [1:0] sel,
	input  wire logic       restart,
	output logic            tick
);
	typedef struct packed {
		logic [4:0] cnt;
		logic       tick;
		logic [5:0] since;
		logic       seen;
		logic [1:0] sel_q;
	} sadc_tick_st_t;

	sadc_tick_st_t r;
	sadc_tick_st_t n;
	logic [4:0]    tc;

	// one pulse every 32/16/8/4 system clocks
	always_comb begin
		tc = sadc_pkg::DIV_TC[sel];
		n = r;
		n.sel_q = sel;
		n.tick = (r.cnt == tc) && !restart;
		if (restart || r.cnt == tc) begin
			n.cnt = 5'h00;
		end else begin
			n.cnt = r.cnt + 5'h01;
		end
		// spacing watch, dropped on restart or a select change
		n.since = r.tick ? 6'h01 : r.since + 6'h01;
		if (restart || sel != r.sel_q) begin
			n.seen = 1'b0;
		end else if (r.tick) begin
			n.seen = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tick = r.tick;

	AST_TICK_PERIOD: assert property (@(posedge clk) disable iff (reset)
		r.tick && r.seen && $stable(sel) |-> r.since == 6'(tc) + 6'h01)
		else $error("converter clock period wrong");
endmodule
